// ==== thm_pkg.sv ====
/*
  Shared constants and types of the thermometer two-wire slave front end.
  Assumes nothing of its surroundings; imported whole by thm_addr_map and thm_i2c_slave.
*/
package thm_pkg;

  // Soft power-on-reset command sent in place of a pointer byte
  localparam logic [7:0] THM_SOFT_POR_CMD = 8'h54;

  // Pointer values that select the four internal registers
  localparam logic [1:0] THM_PTR_TEMP = 2'h0;
  localparam logic [1:0] THM_PTR_CONFIG = 2'h1;
  localparam logic [1:0] THM_PTR_HYST = 2'h2;
  localparam logic [1:0] THM_PTR_OVER = 2'h3;
  localparam logic [1:0] THM_PTR_RESET = THM_PTR_TEMP;

  // Pointer byte layout: upper field must be zero, low field selects
  localparam int THM_PTR_SEL_WIDTH = 2;
  localparam logic [5:0] THM_PTR_UPPER_ZERO = 6'h00;

  // Bit counter positions inside one nine-clock byte transfer
  localparam logic [3:0] THM_BIT_FIRST = 4'h1;
  localparam logic [3:0] THM_BIT_LAST = 4'h7;
  localparam logic [3:0] THM_BYTE_DONE = 4'h8;
  localparam logic [3:0] THM_ACK_SLOT = 4'h9;

  // Data bytes carried by each register
  localparam logic [1:0] THM_LEN_NONE = 2'h0;
  localparam logic [1:0] THM_LEN_NARROW = 2'h1;
  localparam logic [1:0] THM_LEN_WIDE = 2'h2;

  // Sensed state of one address select pin
  localparam logic [1:0] THM_TRIT_LOW = 2'h0;
  localparam logic [1:0] THM_TRIT_HIGH = 2'h1;
  localparam logic [1:0] THM_TRIT_FLOAT = 2'h2;

  // Cycles after reset release before the synchronised straps are caught
  localparam logic [1:0] THM_STRAP_WAIT = 2'h3;
  localparam logic [1:0] THM_STRAP_TAKE = 2'h1;

  // Bus address per pin combination, index = pin2*9 + pin1*3 + pin0
  localparam int THM_ADDR_ENTRIES = 27;
  localparam logic [6:0] THM_ADDR_TABLE [THM_ADDR_ENTRIES] = '{
    7'h48, 7'h49, 7'h2c, 7'h4a, 7'h4b, 7'h2d, 7'h28, 7'h29, 7'h35,
    7'h4c, 7'h4d, 7'h2e, 7'h4e, 7'h4f, 7'h2f, 7'h2a, 7'h2b, 7'h36,
    7'h70, 7'h72, 7'h71, 7'h73, 7'h75, 7'h74, 7'h76, 7'h77, 7'h37
  };

  // Protocol states; Gray steps along idle, address, pointer, write data
  typedef enum logic [2:0] {
    THM_ST_IDLE = 3'h0,
    THM_ST_ADDR = 3'h1,
    THM_ST_PTR = 3'h3,
    THM_ST_WDATA = 3'h2,
    THM_ST_READ = 3'h6,
    THM_ST_IGNORE = 3'h7
  } thm_state_type;

endpackage

// ==== thm_addr_if.sv ====
/*
  Carrier between the slave core and its address lookup.
  Assumes the core drives the sensed pin states and reads the address back.
*/
`timescale 1ns/100ps
interface thm_addr_if;
  logic [5:0] pinTrits;
  logic [6:0] busAddr;
  modport mapper (input pinTrits, output busAddr);
  modport core (output pinTrits, input busAddr);
endinterface

// ==== thm_addr_map.sv ====
/*
  Lookup from the three sensed select-pin states to the 7-bit bus address.
  Assumes stable, already captured pin states; purely combinational.
*/
`timescale 1ns/100ps
module thm_addr_map
  import thm_pkg::*;
(
  thm_addr_if.mapper addrIf
);

  logic [4:0] weighted [3];

  // Each pin contributes its state times its base-three weight
  for (genvar i = 0; i < 3; i++) begin : g_pin
    localparam logic [4:0] WEIGHT = (i == 0) ? 5'h01 : ((i == 1) ? 5'h03 : 5'h09);
    logic [4:0] trit;
    assign trit = {3'h0, addrIf.pinTrits[2*i+:2]};
    assign weighted[i] = 5'(trit * WEIGHT);
  end

  logic [4:0] index;
  assign index = 5'(weighted[0] + weighted[1] + weighted[2]);

  // An unused code (pin state 3) cannot arise, but clamp to stay in table
  assign addrIf.busAddr = (index < 5'(THM_ADDR_ENTRIES)) ? THM_ADDR_TABLE[index]
                                                        : THM_ADDR_TABLE[0]; // R4

endmodule

// ==== thm_i2c_slave.sv ====
/*
  Two-wire serial slave front end of a thermometer: address decode, pointer,
  write, read and soft power-on reset. Assumes the scl and sda pins and the
  select-pin sense signals are asynchronous; register contents live outside
  and answer on regSel / rdData within the same clock.
*/
// Overview of operation
// R1: Pointer byte has six zero upper bits; two low bits select the register.
// R2: Address byte holds seven address bits MSB first, direction in bit 0.
// R3: Each select pin is sensed low, high or floating: 27 addresses.
// R4: Sensed pin states map to the address through a fixed 27-entry table.
// R5: Bytes move MSB first, one bit per serial clock period.
// R6: Data changes only while clock is low, except START and STOP.
// R7: Master opens each transaction with START and closes with STOP.
// R8: Receiver answers each byte with ACK or NACK in a ninth clock.
// R9: Write: matching address with direction 0 is acknowledged.
// R10: Next byte is the pointer, acknowledged; data bytes follow at once.
// R11: Master writes one byte to configuration, two to thresholds.
// R12: Device acknowledges each written data byte; master ends with STOP.
// R13: Byte 0x54 after a write address resets everything and is not acked.
// R14: Pointer holds between transactions so reads need no new pointer.
// R15: Read: direction 1 is acknowledged, data driven on the next clock.
// R16: Configuration read returns one byte; master NACKs then STOPs.
// R17: Other reads return two bytes; master ACKs first, NACKs second.
// R18: Master NACK after the first byte ends a two-byte read early.
// R19: New register read: write pointer, repeated START, then read.
// R20: Pointer 00 temperature, 01 configuration, 10 hysteresis, 11 over-limit.
// R21: Power-up and soft reset point at the temperature register.
// R22: Master sends a fresh pointer in every write transaction.
// R23: Foreign addresses are ignored, data line released, until next START.
`timescale 1ns/100ps
module thm_i2c_slave
  import thm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic [2:0] addrSelectPinLevel,
  input wire logic [2:0] addrSelectPinFloat,
  output logic [1:0] regSel,
  input wire logic [15:0] rdData,
  output logic wrStrobe,
  output logic wrByteIdx,
  output logic [7:0] wrData,
  output logic softReset,
  output logic [6:0] busAddr
);

  thm_addr_if addrIf ();

  thm_addr_map u_addr_map (
    .addrIf (addrIf.mapper)
  );

  // Two-stage synchronisers for the link pins, then one stage for edges
  logic [1:0] sclSyncQ;
  logic [1:0] sdaSyncQ;
  logic sclPrevQ;
  logic sdaPrevQ;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclSyncQ <= 2'h3;
      sdaSyncQ <= 2'h3;
      sclPrevQ <= 1'b1;
      sdaPrevQ <= 1'b1;
    end else begin
      sclSyncQ <= {sclSyncQ[0], scl};
      sdaSyncQ <= {sdaSyncQ[0], sdaIn};
      sclPrevQ <= sclSyncQ[1];
      sdaPrevQ <= sdaSyncQ[1];
    end
  end

  logic sclS;
  logic sdaS;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;
  logic busEvent;

  // Bus conditions seen on the synchronised copies
  assign sclS = sclSyncQ[1];
  assign sdaS = sdaSyncQ[1];
  assign sclRise = sclS && !sclPrevQ;
  assign sclFall = !sclS && sclPrevQ;
  assign startDet = sclS && sclPrevQ && sdaPrevQ && !sdaS; // R7
  assign stopDet = sclS && sclPrevQ && !sdaPrevQ && sdaS; // R7
  assign busEvent = startDet || stopDet;

  // Select-pin sense lines are synchronised before the strap capture
  logic [2:0] lvlSync1Q;
  logic [2:0] lvlSync2Q;
  logic [2:0] fltSync1Q;
  logic [2:0] fltSync2Q;
  logic [2:0] strapLvlQ;
  logic [2:0] strapFltQ;
  logic [1:0] strapWaitQ;
  logic softResetQ;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lvlSync1Q <= 3'h0;
      lvlSync2Q <= 3'h0;
      fltSync1Q <= 3'h0;
      fltSync2Q <= 3'h0;
    end else begin
      lvlSync1Q <= addrSelectPinLevel;
      lvlSync2Q <= lvlSync1Q;
      fltSync1Q <= addrSelectPinFloat;
      fltSync2Q <= fltSync1Q;
    end
  end

  // Straps are caught after release and again after a soft reset,
  // so a re-strapped board behaves as after a power cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strapWaitQ <= THM_STRAP_WAIT;
      strapLvlQ <= 3'h0;
      strapFltQ <= 3'h0;
    end else if (softResetQ) begin
      strapWaitQ <= THM_STRAP_WAIT;
    end else if (strapWaitQ != 2'h0) begin
      strapWaitQ <= 2'(strapWaitQ - 2'h1);
      if (strapWaitQ == THM_STRAP_TAKE) begin
        strapLvlQ <= lvlSync2Q;
        strapFltQ <= fltSync2Q;
      end
    end
  end

  // Three-level sense per pin; floating wins over the level reading
  for (genvar i = 0; i < 3; i++) begin : g_trit
    assign addrIf.pinTrits[2*i+:2] = strapFltQ[i] ? THM_TRIT_FLOAT
                                    : (strapLvlQ[i] ? THM_TRIT_HIGH : THM_TRIT_LOW); // R3
  end

  assign busAddr = addrIf.busAddr;

  thm_state_type stateQ;
  logic [3:0] bitCntQ;
  logic [7:0] shiftQ;
  logic [7:0] txQ;
  logic [7:0] rdLowQ;
  logic [1:0] cntQ;
  logic [1:0] ptrQ;
  logic mAckQ;
  logic sdaOeNQ;

  logic byteDone;
  logic slotDone;
  logic txShift;
  logic addrHit;
  logic porCmd;
  logic ptrOk;
  logic [1:0] wrLen;
  logic [1:0] rdLen;
  logic wrOk;
  logic ackNow;
  logic readGo;

  // Byte framing and per-state decisions
  assign byteDone = sclFall && (bitCntQ == THM_BYTE_DONE); // R8
  assign slotDone = sclFall && (bitCntQ == THM_ACK_SLOT); // R8
  assign txShift = sclFall && (stateQ == THM_ST_READ)
                   && (bitCntQ >= THM_BIT_FIRST) && (bitCntQ <= THM_BIT_LAST);
  assign addrHit = (shiftQ[7:1] == addrIf.busAddr); // R2
  assign porCmd = (shiftQ == THM_SOFT_POR_CMD); // R13
  assign ptrOk = (shiftQ[7:THM_PTR_SEL_WIDTH] == THM_PTR_UPPER_ZERO); // R1
  assign wrLen = (ptrQ == THM_PTR_TEMP) ? THM_LEN_NONE
               : ((ptrQ == THM_PTR_CONFIG) ? THM_LEN_NARROW : THM_LEN_WIDE); // R11
  assign rdLen = (ptrQ == THM_PTR_CONFIG) ? THM_LEN_NARROW : THM_LEN_WIDE; // R16 R17
  assign wrOk = (cntQ < wrLen);
  assign readGo = (cntQ == 2'h0) || (mAckQ && (cntQ < rdLen)); // R18

  // Whether the byte just completed earns an acknowledge
  always_comb begin
    case (stateQ)
      THM_ST_ADDR: ackNow = addrHit; // R9 R15
      THM_ST_PTR: ackNow = ptrOk && !porCmd; // R10 R13
      THM_ST_WDATA: ackNow = wrOk; // R12
      default: ackNow = 1'b0; // R23
    endcase
  end

  // Protocol state; any START restarts address reception
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stateQ <= THM_ST_IDLE;
    end else if (startDet) begin
      stateQ <= THM_ST_ADDR; // R19
    end else if (stopDet) begin
      stateQ <= THM_ST_IDLE;
    end else if (byteDone) begin
      case (stateQ)
        THM_ST_ADDR: begin
          if (!addrHit) begin
            stateQ <= THM_ST_IGNORE; // R23
          end else begin
            stateQ <= shiftQ[0] ? THM_ST_READ : THM_ST_PTR; // R9 R15
          end
        end
        THM_ST_PTR: begin
          if (porCmd) begin
            stateQ <= THM_ST_IDLE; // R13
          end else begin
            stateQ <= ptrOk ? THM_ST_WDATA : THM_ST_IGNORE; // R10
          end
        end
        THM_ST_WDATA: stateQ <= wrOk ? THM_ST_WDATA : THM_ST_IGNORE; // R11
        default: stateQ <= stateQ;
      endcase
    end else if (slotDone && (stateQ == THM_ST_READ) && !readGo) begin
      stateQ <= THM_ST_IGNORE; // R18
    end
  end

  // Bit counter: rises count bits, the fall after the ninth clears it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bitCntQ <= 4'h0;
    end else if (startDet || slotDone) begin
      bitCntQ <= 4'h0;
    end else if (sclRise && (bitCntQ < THM_ACK_SLOT)) begin
      bitCntQ <= 4'(bitCntQ + 4'h1); // R5
    end
  end

  // Receive shifter samples on rising clock, MSB first; master answer too
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shiftQ <= 8'h00;
      mAckQ <= 1'b0;
    end else if (sclRise) begin
      if (bitCntQ < THM_BYTE_DONE) begin
        shiftQ <= {shiftQ[6:0], sdaS}; // R5
      end
      if (bitCntQ == THM_BYTE_DONE) begin
        mAckQ <= !sdaS; // R17
      end
    end
  end

  // Bytes counted per transaction: written data or sent data
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cntQ <= 2'h0;
    end else if (startDet) begin
      cntQ <= 2'h0;
    end else if (byteDone && (stateQ == THM_ST_READ)) begin
      cntQ <= 2'(cntQ + 2'h1);
    end else if (byteDone && (stateQ == THM_ST_WDATA) && wrOk) begin
      cntQ <= 2'(cntQ + 2'h1);
    end
  end

  // Both read bytes are taken at once so a two-byte read is coherent
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      txQ <= 8'h00;
      rdLowQ <= 8'h00;
    end else if (byteDone && (stateQ == THM_ST_ADDR) && addrHit && shiftQ[0]) begin
      txQ <= rdData[15:8]; // R15
      rdLowQ <= rdData[7:0];
    end else if (txShift) begin
      txQ <= {txQ[6:0], 1'b0}; // R5
    end else if (slotDone && (stateQ == THM_ST_READ) && readGo && (cntQ != 2'h0)) begin
      txQ <= rdLowQ; // R17
    end
  end

  // Pointer survives transactions; only a pointer byte or reset moves it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ptrQ <= THM_PTR_RESET; // R21
    end else if (byteDone && (stateQ == THM_ST_PTR)) begin
      if (porCmd) begin
        ptrQ <= THM_PTR_RESET; // R21
      end else if (ptrOk) begin
        ptrQ <= shiftQ[1:0]; // R20 R22
      end
    end
  end

  assign regSel = ptrQ; // R14

  // Open-drain data line, enable low pulls low; changes only on a fall or at START/STOP
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sdaOeNQ <= 1'b1;
    end else if (busEvent) begin
      sdaOeNQ <= 1'b1;
    end else if (byteDone) begin
      sdaOeNQ <= !ackNow; // R8 R9 R10 R12 R13 R23
    end else if (slotDone) begin
      if ((stateQ == THM_ST_READ) && readGo) begin
        sdaOeNQ <= (cntQ == 2'h0) ? txQ[7] : rdLowQ[7]; // R15
      end else begin
        sdaOeNQ <= 1'b1;
      end
    end else if (txShift) begin
      sdaOeNQ <= txQ[6]; // R5 R6
    end
  end

  assign sdaOeN = sdaOeNQ;
  assign sdaOut = 1'b0;

  // Write strobe to the register file and soft reset pulse
  logic wrStrobeQ;
  logic wrByteIdxQ;
  logic [7:0] wrDataQ;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wrStrobeQ <= 1'b0;
      wrByteIdxQ <= 1'b0;
      wrDataQ <= 8'h00;
      softResetQ <= 1'b0;
    end else begin
      wrStrobeQ <= byteDone && (stateQ == THM_ST_WDATA) && wrOk; // R12
      softResetQ <= byteDone && (stateQ == THM_ST_PTR) && porCmd; // R13
      if (byteDone && (stateQ == THM_ST_WDATA)) begin
        wrByteIdxQ <= cntQ[0];
        wrDataQ <= shiftQ;
      end
    end
  end

  assign wrStrobe = wrStrobeQ;
  assign wrByteIdx = wrByteIdxQ;
  assign wrData = wrDataQ;
  assign softReset = softResetQ;

  // Checks on the slave's own behaviour
  sequence s_ptrByte;
    byteDone && (stateQ == THM_ST_PTR);
  endsequence

  sequence s_readSlot;
    slotDone && (stateQ == THM_ST_READ);
  endsequence

  property p_addr_ack;
    @(posedge clock) disable iff (!rst_n)
    byteDone && (stateQ == THM_ST_ADDR) && addrHit |=> !sdaOeNQ [*1] ##1 1'b1;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged"); // R9

  property p_foreign;
    @(posedge clock) disable iff (!rst_n)
    byteDone && (stateQ == THM_ST_ADDR) && !addrHit |=> sdaOeNQ && (stateQ == THM_ST_IGNORE);
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign address answered"); // R23

  property p_ignore_quiet;
    @(posedge clock) disable iff (!rst_n)
    (stateQ == THM_ST_IGNORE) && $past(stateQ == THM_ST_IGNORE) |-> sdaOeNQ;
  endproperty
  a_ignore_quiet: assert property (p_ignore_quiet) else $error("line pulled while ignoring"); // R23

  property p_por;
    @(posedge clock) disable iff (!rst_n)
    s_ptrByte and porCmd |=> sdaOeNQ && softResetQ && (ptrQ == THM_PTR_TEMP)
      ##1 !softResetQ;
  endproperty
  a_por: assert property (p_por) else $error("soft reset misbehaved"); // R13

  property p_ptr_load;
    @(posedge clock) disable iff (!rst_n)
    s_ptrByte and ptrOk and !porCmd |=> (ptrQ == $past(shiftQ[1:0])) && !sdaOeNQ;
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded"); // R20

  property p_wr_strobe;
    @(posedge clock) disable iff (!rst_n)
    byteDone && (stateQ == THM_ST_WDATA) && wrOk |=> wrStrobe && !sdaOeNQ
      && (wrData == $past(shiftQ));
  endproperty
  a_wr_strobe: assert property (p_wr_strobe) else $error("written byte lost"); // R12

  property p_first_bit;
    @(posedge clock) disable iff (!rst_n)
    s_readSlot and (cntQ == 2'h0) |=> (sdaOeNQ == $past(txQ[7]));
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("read data late"); // R15

  property p_nack_end;
    @(posedge clock) disable iff (!rst_n)
    s_readSlot and (cntQ != 2'h0) and !mAckQ |=> (stateQ == THM_ST_IGNORE) && sdaOeNQ;
  endproperty
  a_nack_end: assert property (p_nack_end) else $error("sent after master nack"); // R18

  property p_stable_high;
    @(posedge clock) disable iff (!rst_n)
    $changed(sdaOeNQ) |-> $past(sclFall) || $past(busEvent);
  endproperty
  a_stable_high: assert property (p_stable_high) else $error("data moved off a fall"); // R6

  property p_nine;
    @(posedge clock) disable iff (!rst_n)
    bitCntQ <= THM_ACK_SLOT;
  endproperty
  a_nine: assert property (p_nine) else $error("byte longer than nine clocks"); // R8

endmodule

// ==== thm_master_model.sv ====
/*
  Behavioural two-wire bus master that faces the thermometer slave front end.
  Assumes the bench resolves the open-drain data wire and feeds it back in.
*/
`timescale 1ns/100ps
module thm_master_model (
  input wire logic clock,
  output logic scl,
  output logic sdaDrvN,
  input wire logic sdaWire
);
  // Idle bus: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sdaDrvN = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  // One bit in eight cycles (200 ns): four low, four high; data moves one
  // cycle after the fall, so the slave's synchronisers never see it race
  task automatic bit_xfer(input logic b, output logic r);
    tick(1);
    sdaDrvN = b;
    tick(3);
    scl = 1'b1;
    tick(2);
    r = sdaWire;
    tick(2);
    scl = 1'b0;
  endtask

  // Works from idle and as a repeated start after a ninth clock
  task automatic start_cond();
    tick(1);
    sdaDrvN = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sdaDrvN = 1'b0;
    tick(4);
    scl = 1'b0;
  endtask

  task automatic stop_cond();
    tick(1);
    sdaDrvN = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sdaDrvN = 1'b1;
    tick(4);
  endtask

  // Eight bits MSB first, then the receiver's answer clock
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, ack);
  endtask

  task automatic read_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, d[i]);
    end
    bit_xfer(nack, r);
  endtask
endmodule

// ==== tb_thermo_i2c_slave_access.sv ====
/*
  Self-checking bench for the thermometer two-wire slave front end.
  Assumes a pull-up on the data wire and register storage modelled here.
*/
`timescale 1ns/100ps
module tb_thermo_i2c_slave_access;
  import thm_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic sclPin, mDrvN, sdaWire, sdaOut, sdaOeN, wrStrobe, wrByteIdx, softReset, ackBit;
  logic [2:0] pinLevel = 3'h0;
  logic [2:0] pinFloat = 3'h0;
  logic [1:0] regSel;
  logic [15:0] rdData, v;
  logic [7:0] wrData, rxByte;
  logic [6:0] busAddr, myAddr;
  logic [15:0] regModel [4];
  logic [8:0] expQ [$];
  int error_cnt = 0;
  int comparisons = 0;
  int softCnt = 0;
  int seed = 5;
  int pick;
  // Expected address per strap index pin2*9 + pin1*3 + pin0
  logic [6:0] addrExp [27] = '{7'h48, 7'h49, 7'h2c, 7'h4a, 7'h4b, 7'h2d, 7'h28, 7'h29, 7'h35,
    7'h4c, 7'h4d, 7'h2e, 7'h4e, 7'h4f, 7'h2f, 7'h2a, 7'h2b, 7'h36,
    7'h70, 7'h72, 7'h71, 7'h73, 7'h75, 7'h74, 7'h76, 7'h77, 7'h37};

  always #12.5 clock = ~clock;

  // Open-drain wire: either party pulling low wins over the pull-up
  assign sdaWire = (sdaOeN ? 1'b1 : sdaOut) & mDrvN;
  assign rdData = regModel[regSel];

  thm_i2c_slave uut (.clock(clock), .rst_n(rst_n), .scl(sclPin), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOeN(sdaOeN), .addrSelectPinLevel(pinLevel),
    .addrSelectPinFloat(pinFloat), .regSel(regSel), .rdData(rdData), .wrStrobe(wrStrobe),
    .wrByteIdx(wrByteIdx), .wrData(wrData), .softReset(softReset), .busAddr(busAddr));

  thm_master_model mst (.clock(clock), .scl(sclPin), .sdaDrvN(mDrvN), .sdaWire(sdaWire));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Strobes must match the oldest expected byte; unexpected ones are errors.
  // Looked at mid-cycle, away from the edge that launches the pulses
  always @(negedge clock) begin
    if (softReset === 1'b1) softCnt++;
    if (wrStrobe === 1'b1) begin
      if (expQ.size() == 0) check({7'h0, wrByteIdx, wrData}, 16'hffff);
      else check({7'h0, wrByteIdx, wrData}, {7'h0, expQ.pop_front()});
      if (wrByteIdx) regModel[regSel][7:0] = wrData;
      else regModel[regSel][15:8] = wrData;
    end
  end

  // Straps are sensed only after reset release or a soft reset, so each change needs one
  task automatic strap(input int idx);
    for (int i = 0; i < 3; i++) begin
      pinLevel[i] = ((idx / (3 ** i)) % 3) == 1;
      pinFloat[i] = ((idx / (3 ** i)) % 3) == 2;
    end
    rst_n = 1'b0;
    mst.tick(6);
    rst_n = 1'b1;
    mst.tick(7);
  endtask

  task automatic write_reg(input logic [7:0] ptr, input int n, input logic [15:0] val,
                           input logic endStop);
    mst.start_cond();
    mst.write_byte({myAddr, 1'b0}, ackBit);
    check(ackBit, 16'h0);
    mst.write_byte(ptr, ackBit);
    check(ackBit, 16'h0);
    for (int i = 0; i < n; i++) begin
      expQ.push_back({i[0], val[15 - 8 * i -: 8]});
      mst.write_byte(val[15 - 8 * i -: 8], ackBit);
      check(ackBit, 16'h0);
    end
    if (endStop) mst.stop_cond();
  endtask

  task automatic read_reg(input int n, input logic [15:0] exp);
    mst.start_cond();
    mst.write_byte({myAddr, 1'b1}, ackBit);
    check(ackBit, 16'h0);
    for (int i = 0; i < n; i++) begin
      mst.read_byte(i == n - 1, rxByte);
      check(rxByte, exp[15 - 8 * i -: 8]);
    end
    mst.tick(4);
    check(sdaOeN, 16'h1);
    mst.stop_cond();
  endtask

  // Two bytes with chosen expected answers, for refusals
  task automatic raw2(input logic [7:0] a, input logic [7:0] b, input logic ea, input logic eb);
    mst.start_cond();
    mst.write_byte(a, ackBit);
    check(ackBit, ea);
    mst.write_byte(b, ackBit);
    check(ackBit, eb);
    mst.stop_cond();
  endtask

  initial begin
    for (int i = 0; i < 4; i++) regModel[i] = $random(seed);
    for (int k = 0; k < 27; k++) begin
      strap(k);
      check(busAddr, addrExp[k]);
      check(regSel, 16'h0);
    end
    $display("Test strap decode done");
    pick = $unsigned($random(seed)) % 27;
    strap(pick);
    myAddr = addrExp[pick];
    read_reg(2, regModel[0]);
    $display("Test default pointer read done");
    v = $random(seed);
    write_reg(8'h01, 1, v, 1'b1);
    check(regSel, 16'h1);
    read_reg(1, {v[15:8], 8'h00});
    v = $random(seed);
    write_reg(8'h03, 2, v, 1'b1);
    check(regSel, 16'h3);
    read_reg(2, v);
    $display("Test write and read back done");
    v = $random(seed);
    write_reg(8'h02, 2, v, 1'b1);
    write_reg(8'h01, 0, 16'h0, 1'b0);
    read_reg(1, {regModel[1][15:8], 8'h00});
    write_reg(8'h02, 0, 16'h0, 1'b0);
    read_reg(1, v);
    $display("Test repeated start and early end done");
    raw2({myAddr, 1'b0}, 8'h43, 1'b0, 1'b1);
    check(regSel, 16'h2);
    raw2({myAddr ^ 7'h01, 1'b0}, 8'h01, 1'b1, 1'b1);
    check(regSel, 16'h2);
    write_reg(8'h00, 0, 16'h0, 1'b0);
    mst.write_byte(v[7:0], ackBit);
    check(ackBit, 16'h1);
    mst.stop_cond();
    write_reg(8'h01, 1, v, 1'b0);
    mst.write_byte(v[7:0], ackBit);
    check(ackBit, 16'h1);
    mst.stop_cond();
    $display("Test refusals done");
    raw2({myAddr, 1'b0}, THM_SOFT_POR_CMD, 1'b0, 1'b1);
    check(softCnt, 16'h1);
    check(regSel, 16'h0);
    read_reg(2, regModel[0]);
    check(expQ.size(), 16'h0);
    $display("Test soft reset done");
    finish_test();
  end

  // Hang guard: the whole run is far shorter than this
  initial begin
    repeat (100000) @(posedge clock);
    error_cnt++;
    finish_test();
  end
endmodule
